//--- ldpf_pkg.sv
// Package for the LCD duty, power and frame interrupt register slice.
// Assumes a 32-bit classic Wishbone slave with byte-wide registers.
package ldpf_pkg;

    // Register word indices; the byte address is four times the index.
    localparam logic [15:0] IDX_DUTY_SELECT = 16'h50A2;
    localparam logic [15:0] IDX_REGULATOR_CONTROL = 16'h50A3;
    localparam logic [15:0] IDX_BOOSTER_CONTROL = 16'h50A4;
    localparam logic [15:0] IDX_FRAME_IRQ_MASK = 16'h50A5;
    localparam logic [15:0] IDX_FRAME_IRQ_FLAG = 16'h50A6;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // Field positions.
    localparam int DUTY_LSB = 0;
    localparam int DUTY_MSB = 1;
    localparam int HEAVY_LOAD_BIT = 4;
    localparam int SOURCE_SEL_BIT = 1;
    localparam int BOOSTER_ON_BIT = 0;
    localparam int FRAME_IE_BIT = 0;
    localparam int FRAME_IF_BIT = 0;

    // Duty codes and reset values.
    localparam logic [1:0] DUTY_1_32 = 2'h2;
    localparam logic [1:0] DUTY_1_16 = 2'h1;
    localparam logic [1:0] DUTY_RESET = DUTY_1_32;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Electrode ranges for each duty.
    localparam logic [6:0] COMMON_LAST_1_32 = 7'h1F;
    localparam logic [6:0] SEGMENT_LAST_1_32 = 7'h37;
    localparam logic [6:0] COMMON_LAST_1_16 = 7'h0F;
    localparam logic [6:0] SEGMENT_LAST_1_16 = 7'h47;

    typedef enum logic [1:0] {
        LDPF_DUTY_1_16 = 2'h1,
        LDPF_DUTY_1_32 = 2'h2
    } ldpf_duty_e;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
    } ldpf_wb_req_s;

    // Drive configuration toward the panel and power blocks.
    typedef struct packed {
        logic duty_1_32;
        logic [6:0] common_last;
        logic [6:0] segment_last;
        logic heavy_load_protect;
        logic regulator_source_sel;
        logic booster_on;
    } ldpf_drive_cfg_s;

endpackage

//--- ldpf_edge_sync.sv
// Two-flop synchroniser with rising-edge pulse on the synchronised level.
// Assumes the input comes from outside the clk_i domain.
`timescale 1ns/100ps
module ldpf_edge_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Level in, edge out
    input wire logic level_i,
    output logic rise_o
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= level_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign rise_o = sync_reg & ~last_reg;
endmodule

//--- ldpf_regs.sv
// Register slice of the LCD driver: duty select, regulator and booster
// control, frame interrupt mask and flag, on a classic Wishbone slave.
// Assumes the frame signal arrives asynchronously and the interrupt
// controller input is level-triggered.
`timescale 1ns/100ps
import ldpf_pkg::*;

module ldpf_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire ldpf_pkg::ldpf_wb_req_s wb_req_i,
    output logic [ldpf_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Frame signal from the timing generator
    input wire logic frame_i,
    // Drive configuration and interrupt request
    output ldpf_pkg::ldpf_drive_cfg_s drive_cfg_o,
    output logic irq_o
);
    import ldpf_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } ldpf_state_e;

    ldpf_state_e state_reg;
    logic [1:0] duty_code_reg;
    logic heavy_load_protect_reg;
    logic regulator_source_sel_reg;
    logic booster_on_reg;
    logic frame_irq_enable_reg;
    logic frame_irq_flag_reg;
    logic frame_irq_flag_next;
    logic frame_rise;
    logic req;
    logic wr_lane0;
    logic hit;
    logic [7:0] rd_byte;
    logic [15:0] idx;

    // Decodes a register index to a one-hot select of the five registers.
    function automatic logic [4:0] reg_sel(input logic [15:0] index);
        logic [4:0] s;
        s = 5'h00;
        case (index)
            IDX_DUTY_SELECT: s = 5'h01;
            IDX_REGULATOR_CONTROL: s = 5'h02;
            IDX_BOOSTER_CONTROL: s = 5'h04;
            IDX_FRAME_IRQ_MASK: s = 5'h08;
            IDX_FRAME_IRQ_FLAG: s = 5'h10;
            default: s = 5'h00;
        endcase
        return s;
    endfunction

    ldpf_edge_sync u_frame_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(frame_i),
        .rise_o(frame_rise)
    );

    assign idx = wb_req_i.adr[ADDR_W-1:2];
    assign req = wb_req_i.cyc & wb_req_i.stb & (state_reg == ST_IDLE);
    assign hit = |reg_sel(idx);
    // Registers live in byte lane 0; other lanes are ignored.
    assign wr_lane0 = req & hit & wb_req_i.we & wb_req_i.sel[0];

    // One wait state: answer in the cycle after the request, then drop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (wb_req_i.cyc & wb_req_i.stb) begin
                        state_reg <= ST_ACK;
                    end
                end
                ST_ACK: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
        end
    end

    // Read data is captured with the request so it is stable at the ack edge.
    always_comb begin
        rd_byte = BYTE_ZERO;
        case (reg_sel(idx))
            5'h01: rd_byte[DUTY_MSB:DUTY_LSB] = duty_code_reg;
            5'h02: rd_byte[HEAVY_LOAD_BIT] = heavy_load_protect_reg;
            5'h04: begin
                rd_byte[SOURCE_SEL_BIT] = regulator_source_sel_reg;
                rd_byte[BOOSTER_ON_BIT] = booster_on_reg;
            end
            5'h08: rd_byte[FRAME_IE_BIT] = frame_irq_enable_reg;
            5'h10: rd_byte[FRAME_IF_BIT] = frame_irq_flag_reg;
            default: rd_byte = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= WORD_ZERO;
        end else if (req & hit & ~wb_req_i.we) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end else begin
            wb_dat_o <= WORD_ZERO;
        end
    end

    // Duty select; reserved codes are stored as written, software avoids them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_code_reg <= DUTY_RESET;
        end else if (wr_lane0 && reg_sel(idx) == 5'h01) begin
            duty_code_reg <= wb_req_i.dat[DUTY_MSB:DUTY_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            heavy_load_protect_reg <= 1'b0;
        end else if (wr_lane0 && reg_sel(idx) == 5'h02) begin
            heavy_load_protect_reg <= wb_req_i.dat[HEAVY_LOAD_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regulator_source_sel_reg <= 1'b0;
            booster_on_reg <= 1'b0;
        end else if (wr_lane0 && reg_sel(idx) == 5'h04) begin
            regulator_source_sel_reg <= wb_req_i.dat[SOURCE_SEL_BIT];
            booster_on_reg <= wb_req_i.dat[BOOSTER_ON_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_irq_enable_reg <= 1'b0;
        end else if (wr_lane0 && reg_sel(idx) == 5'h08) begin
            frame_irq_enable_reg <= wb_req_i.dat[FRAME_IE_BIT];
        end
    end

    // A frame edge in the same cycle as a clearing write keeps the flag set.
    always_comb begin
        frame_irq_flag_next = frame_irq_flag_reg;
        if (wr_lane0 && reg_sel(idx) == 5'h10 && wb_req_i.dat[FRAME_IF_BIT]) begin
            frame_irq_flag_next = 1'b0;
        end
        if (frame_rise) begin
            frame_irq_flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_irq_flag_reg <= 1'b0;
        end else begin
            frame_irq_flag_reg <= frame_irq_flag_next;
        end
    end

    // The request is registered from the next flag so it tracks the flag
    // without an extra cycle of lag; software must use level trigger.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= frame_irq_flag_next & frame_irq_enable_reg;
        end
    end

    // Drive configuration outputs, each straight from a flip-flop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_cfg_o.duty_1_32 <= 1'b1;
            drive_cfg_o.common_last <= COMMON_LAST_1_32;
            drive_cfg_o.segment_last <= SEGMENT_LAST_1_32;
            drive_cfg_o.heavy_load_protect <= 1'b0;
            drive_cfg_o.regulator_source_sel <= 1'b0;
            drive_cfg_o.booster_on <= 1'b0;
        end else begin
            drive_cfg_o.duty_1_32 <= (duty_code_reg == DUTY_1_32);
            drive_cfg_o.common_last <= (duty_code_reg == DUTY_1_16) ?
                COMMON_LAST_1_16 : COMMON_LAST_1_32;
            drive_cfg_o.segment_last <= (duty_code_reg == DUTY_1_16) ?
                SEGMENT_LAST_1_16 : SEGMENT_LAST_1_32;
            drive_cfg_o.heavy_load_protect <= heavy_load_protect_reg;
            drive_cfg_o.regulator_source_sel <= regulator_source_sel_reg;
            drive_cfg_o.booster_on <= booster_on_reg;
        end
    end
endmodule

//--- ldpf_frame_src.sv
// Frame timing source model that drives the frame level into the slice.
// Assumes fire_i is a one-cycle request from the bench.
`timescale 1ns/100ps
module ldpf_frame_src (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request and frame level
    input wire logic fire_i,
    output logic frame_o
);
    logic [2:0] cnt_reg;
    // The level stays up several cycles so the two-flop synchroniser sees it.
    always_ff @(posedge clk_i) begin
        if (rst_i) cnt_reg <= 3'h0;
        else if (fire_i) cnt_reg <= 3'h5;
        else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
    end
    assign frame_o = (cnt_reg != 3'h0);
endmodule

//--- ldpf_regs_sva.sv
// Bus, field and interrupt checker for the LCD register slice.
// Assumes it is bound to ldpf_regs and sees only its ports.
`timescale 1ns/100ps
module ldpf_regs_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Observed ports
    input wire ldpf_pkg::ldpf_wb_req_s wb_req_i,
    input wire logic [ldpf_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic frame_i,
    input wire ldpf_pkg::ldpf_drive_cfg_s drive_cfg_o,
    input wire logic irq_o
);
    import ldpf_pkg::*;
    logic mapped;
    assign mapped = wb_req_i.adr inside {18'h14288, 18'h1428C, 18'h14290,
                                         18'h14294, 18'h14298};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_clear;
        s_take ##0 (wb_req_i.we && wb_req_i.sel[0] && wb_req_i.dat[0]
                    && wb_req_i.adr == 18'h14298);
    endsequence
    a_ack_pulse: assert property ((wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o)
        else $error("answer held longer than one cycle");
    a_ack_mapped: assert property (s_take ##0 mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acknowledged");
    a_err_unmapped: assert property (s_take ##0 !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack cycle");
    a_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_duty_ranges: assert property (drive_cfg_o.duty_1_32 |->
        drive_cfg_o.common_last == 7'h1F && drive_cfg_o.segment_last == 7'h37)
        else $error("wrong electrode ranges");
    a_cfg_by_write: assert property (!$stable(drive_cfg_o) |->
        $past(wb_ack_o) && $past(wb_req_i.we))
        else $error("configuration changed without a write");
    a_irq_clear_write: assert property (s_clear ##0
        (!$past(frame_i) && !$past(frame_i, 2)) |=> !irq_o [*2])
        else $error("request not dropped by flag clear");
endmodule

//--- tb_ldpf_regs.sv
// Self-checking bench for the LCD duty, power and frame interrupt slice.
// Assumes a 10 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tb_ldpf_regs;
    import ldpf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fire = 1'b0;
    logic frame_i;
    logic irq_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic [DATA_W-1:0] wb_dat_o;
    logic [31:0] q;
    logic e;
    ldpf_wb_req_s wb_req_i = '0;
    ldpf_drive_cfg_s drive_cfg_o;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc_cnt = 0;
    logic [17:0] adrs [5] = '{18'h14288, 18'h1428C, 18'h14290, 18'h14294, 18'h14298};
    logic [7:0] rst_v [5] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ff_v [5] = '{8'h03, 8'h10, 8'h03, 8'h01, 8'h00};
    initial forever #50 clk_i = ~clk_i;
    ldpf_regs u_ldpf_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .frame_i(frame_i), .drive_cfg_o(drive_cfg_o), .irq_o(irq_o));
    ldpf_frame_src u_ldpf_frame_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .frame_o(frame_i));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // A run of under two hundred cycles; the ceiling leaves ample margin.
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            end_of_test;
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    // The drive outputs follow a write by one more edge, so look mid-cycle.
    task automatic chk_cfg(input logic d, input logic [6:0] c, input logic [6:0] s,
                           input logic [2:0] p);
        @(negedge clk_i);
        chk("drive_cfg", {14'h0000, d, c, s, p}, {14'h0000, drive_cfg_o});
    endtask
    // Ack, error and read data are taken at the rising edge that samples ack or
    // error high; the request is held unchanged until that edge and released there.
    task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wb_req_i <= '{1'b1, 1'b1, w, 4'hF, a, {24'h00_0000, d}};
        do @(posedge clk_i); while (!wb_ack_o && !wb_err_o);
        q = wb_dat_o;
        e = wb_err_o;
        wb_req_i <= '0;
    endtask
    task automatic rd(input logic [17:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h00_0000, x}, q);
    endtask
    task automatic pulse_frame;
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (10) @(negedge clk_i);
    endtask
    task automatic irq_is(input logic x);
        repeat (2) @(negedge clk_i);
        chk("irq", {31'h0, x}, {31'h0, irq_o});
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) rd(adrs[i], rst_v[i]);
        chk_cfg(1'b1, 7'h1F, 7'h37, 3'h0);
        $display("test reset done");
        for (int i = 0; i < 5; i++) bus(1'b1, adrs[i], 8'hFF);
        for (int i = 0; i < 5; i++) rd(adrs[i], ff_v[i]);
        chk_cfg(1'b0, 7'h1F, 7'h37, 3'h7);
        bus(1'b1, adrs[0], 8'h01);
        chk_cfg(1'b0, 7'h0F, 7'h47, 3'h7);
        bus(1'b1, adrs[0], 8'h02);
        chk_cfg(1'b1, 7'h1F, 7'h37, 3'h7);
        $display("test fields done");
        bus(1'b0, 18'h14000, 8'h00);
        chk("err", 32'h1, {31'h0, e});
        bus(1'b1, 18'h1429C, 8'hFF);
        chk("err", 32'h1, {31'h0, e});
        $display("test unmapped done");
        bus(1'b1, adrs[3], 8'h00);
        bus(1'b1, adrs[4], 8'h01);
        pulse_frame;
        irq_is(1'b0);
        rd(adrs[4], 8'h01);
        bus(1'b1, adrs[4], 8'hFE);
        rd(adrs[4], 8'h01);
        bus(1'b1, adrs[3], 8'h01);
        irq_is(1'b1);
        bus(1'b1, adrs[4], 8'h01);
        irq_is(1'b0);
        rd(adrs[4], 8'h00);
        pulse_frame;
        irq_is(1'b1);
        bus(1'b1, adrs[4], 8'h01);
        irq_is(1'b0);
        $display("test frame done");
        end_of_test;
    end
endmodule
bind ldpf_regs ldpf_regs_sva u_ldpf_regs_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .frame_i(frame_i), .drive_cfg_o(drive_cfg_o), .irq_o(irq_o));
